/* File: core/srq_ctrl.v */
// Purpose: Service request controller: nodes, transfer channels, traps.
// Assumes: Sources, software strobes and CPU acknowledges are on mclk_i.
// Notes:   The rules that the logic below carries out are listed next.
// Operation
// - Each node is routed to a vectored interrupt or a transfer service.
// - A vectored service suspends the program and branches to the vector.
// - A transfer service steals exactly one cycle, with no branch.
// - A transfer moves byte or word, then bumps source and/or destination.
// - Count decrements unless continuous; at zero an interrupt follows.
// - Eight independent transfer channels.
// - Response latency is 7 clocks with jump cache, 11 without.
// - 46 nodes, each with request flag, enable and priority.
// - The last nodes are shared; a select input picks their source.
// - Four edge channels, a routing matrix and four output gates.
// - Each edge channel detects rising, falling or both edges.
// - Each gate filters its combined events on pattern hit or miss.
// - A hardware trap branches at once to its own vector.
// - Every trap occurrence sets its own indicator bit.
// - A trap preempts anything but a trap service of equal or higher priority.
// - Interrupts and transfers wait while a trap service runs.
// - Three service request pins yield two system request traps.
// - A trap instruction raises an interrupt at the given number.
// - A software set of a request flag acts like a hardware source.
`timescale 1ns/1ns
`default_nettype none
`include "srq_defs.vh"
module srq_ctrl #(
   parameter NODES   = `SRQ_NODES,
   parameter CHANS   = `SRQ_CHANS,
   parameter HWTRAPS = `SRQ_HWTRAPS
) (
   input  wire                          mclk_i,
   input  wire                          rst_n_i,
   input  wire [NODES-1:0]              src_req_i,
   input  wire [NODES-1:0]              node_set_i,
   input  wire [NODES-1:0]              node_en_i,
   input  wire [NODES*`SRQ_PRIO_W-1:0]  node_prio_i,
   input  wire [NODES-1:0]              node_xfer_i,
   input  wire [NODES*3-1:0]            node_chan_i,
   input  wire [`SRQ_SHARED-1:0]        node_source_select_i,
   input  wire [`SRQ_ERU_CH-1:0]        eru_pin_i,
   input  wire [2*`SRQ_ERU_CH-1:0]      eru_edge_i,
   input  wire [4*`SRQ_ERU_CH-1:0]      eru_route_i,
   input  wire [4*`SRQ_ERU_CH-1:0]      eru_pat_i,
   input  wire [2*`SRQ_ERU_CH-1:0]      eru_gmode_i,
   input  wire [`SRQ_ESR_PINS-1:0]      service_request_pin_i,
   input  wire [`SRQ_ESR_PINS-1:0]      esr_en_i,
   input  wire [HWTRAPS-1:0]            hw_trap_i,
   input  wire [HWTRAPS+1:0]            trap_clr_i,
   input  wire                          trap_done_i,
   input  wire                          sw_trap_i,
   input  wire [6:0]                    sw_trap_num_i,
   input  wire                          jump_cache_i,
   input  wire                          int_done_i,
   input  wire                          chan_wr_i,
   input  wire [2:0]                    chan_idx_i,
   input  wire [`SRQ_PTR_W-1:0]         chan_src_i,
   input  wire [`SRQ_PTR_W-1:0]         chan_dst_i,
   input  wire [`SRQ_CNT_W-1:0]         chan_cnt_i,
   input  wire [CHANS*`SRQ_CB_W-1:0]    chan_cfg_i,
   output wire [NODES-1:0]              pending_request_bit_o,
   output wire                          int_active_o,
   output wire                          vec_take_o,
   output wire [6:0]                    vec_num_o,
   output wire                          steal_o,
   output wire [`SRQ_PTR_W-1:0]         xfer_src_o,
   output wire [`SRQ_PTR_W-1:0]         xfer_dst_o,
   output wire                          xfer_word_o,
   output wire [2:0]                    xfer_chan_o,
   output wire [HWTRAPS+1:0]            trap_indicator_register_o,
   output wire                          trap_active_o,
   output wire                          trap_take_o,
   output wire [3:0]                    trap_vec_o,
   output wire [`SRQ_ERU_CH-1:0]        eru_evt_o
);
   localparam NT      = HWTRAPS + 2;
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_XFER = 3'b100;

   reg [2:0]             state_r;
   reg [3:0]             lat_r;
   reg [NODES-1:0]       req_r;
   reg [NODES-1:0]       force_r;
   reg                   int_act_r;
   reg                   sw_pend_r;
   reg [6:0]             vec_r;
   reg [`SRQ_PTR_W-1:0]  src_ptr_r [0:CHANS-1];
   reg [`SRQ_PTR_W-1:0]  dst_ptr_r [0:CHANS-1];
   reg [`SRQ_CNT_W-1:0]  cnt_r     [0:CHANS-1];
   reg [`SRQ_PTR_W-1:0]  xsrc_r;
   reg [`SRQ_PTR_W-1:0]  xdst_r;
   reg                   xword_r;
   reg [2:0]             xchan_r;
   reg [NT-1:0]          tflag_r;
   reg [NT-1:0]          tpend_r;
   reg                   tact_r;
   reg [3:0]             tlvl_r;
   reg                   ttake_r;
   reg [3:0]             tvec_r;
   reg [`SRQ_ERU_CH-1:0] gate_r;

   wire [`SRQ_ERU_CH-1:0]   eru_lvl;
   wire [`SRQ_ERU_CH-1:0]   eru_evt;
   wire [`SRQ_ESR_PINS-1:0] esr_evt;
   wire [`SRQ_ERU_CH-1:0]   gate_nxt;
   wire [NODES-1:0]         src_eff;

   // Returns the channel configuration word of one channel.
   function [`SRQ_CB_W-1:0] cfg_of;
      input [2:0] ch;
      begin
         cfg_of = chan_cfg_i[ch*`SRQ_CB_W +: `SRQ_CB_W];
      end
   endfunction

   // Edge channels of the routing block and the service request pins.
   genvar g;
   generate
      for (g = 0; g < `SRQ_ERU_CH; g = g + 1) begin : g_eru
         wire [3:0] pat  = eru_pat_i[4*g +: 4];
         wire [1:0] gm   = eru_gmode_i[2*g +: 2];
         wire       any  = |(eru_evt & eru_route_i[4*g +: 4]);
         wire       hit  = (eru_lvl == pat);
         srq_edge_stage u_edge (
            .mclk_i  (mclk_i),
            .rst_n_i (rst_n_i),
            .pin_i   (eru_pin_i[g]),
            .mode_i  (eru_edge_i[2*g +: 2]),
            .level_o (eru_lvl[g]),
            .evt_o   (eru_evt[g])
         );
         // Gate passes events always, only on pattern hit, or on miss.
         assign gate_nxt[g] = any & ((gm == `SRQ_GATE_ALL) |
                              ((gm == `SRQ_GATE_HIT) & hit) |
                              ((gm == `SRQ_GATE_MISS) & ~hit));
      end
      for (g = 0; g < `SRQ_ESR_PINS; g = g + 1) begin : g_esr
         srq_edge_stage u_esr (
            .mclk_i  (mclk_i),
            .rst_n_i (rst_n_i),
            .pin_i   (service_request_pin_i[g]),
            .mode_i  (esr_en_i[g] ? `SRQ_EDGE_RISE : 2'h0),
            .level_o (),
            .evt_o   (esr_evt[g])
         );
      end
      // Dedicated nodes take their own source; shared ones are selected.
      for (g = 0; g < NODES; g = g + 1) begin : g_src
         if (g >= NODES - `SRQ_SHARED) begin : g_sh
            assign src_eff[g] =
               node_source_select_i[g-(NODES-`SRQ_SHARED)] ?
               gate_r[g-(NODES-`SRQ_SHARED)] : src_req_i[g];
         end else begin : g_ded
            assign src_eff[g] = src_req_i[g];
         end
      end
   endgenerate

   // Two system request traps sit above the hardware trap sources.
   wire [NT-1:0] trap_ev = {esr_evt[1] | esr_evt[2], esr_evt[0],
                            hw_trap_i};

   // Arbiter: highest priority among enabled pending nodes, lowest index
   // on a tie. Standard interrupts do not nest, so they wait while one
   // is active; transfers still run then.
   reg                  best_v;
   reg [5:0]            best_i;
   reg [`SRQ_PRIO_W-1:0] best_p;
   reg                  best_x;
   reg                  elig_x;
   reg [2:0]            ch;
   reg [`SRQ_CB_W-1:0]  cfg_v;
   integer              i;
   always @* begin
      best_v = 1'b0;
      best_i = 6'h00;
      best_p = {`SRQ_PRIO_W{1'b0}};
      best_x = 1'b0;
      elig_x = 1'b0;
      ch     = 3'h0;
      cfg_v  = {`SRQ_CB_W{1'b0}};
      for (i = 0; i < NODES; i = i + 1) begin
         ch    = node_chan_i[i*3 +: 3];
         cfg_v = cfg_of(ch);
         // An exhausted count turns the service into an interrupt.
         elig_x = node_xfer_i[i] & ~force_r[i] &
                  ((cnt_r[ch] != {`SRQ_CNT_W{1'b0}}) |
                   cfg_v[`SRQ_CB_CONT]);
         if (req_r[i] & node_en_i[i] & (elig_x | ~int_act_r) &
             (~best_v |
              (node_prio_i[i*`SRQ_PRIO_W +: `SRQ_PRIO_W] > best_p))) begin
            best_v = 1'b1;
            best_i = i[5:0];
            best_p = node_prio_i[i*`SRQ_PRIO_W +: `SRQ_PRIO_W];
            best_x = elig_x;
         end
      end
   end

   // Highest pending trap; higher index means higher trap priority.
   reg       tp_v;
   reg [3:0] tp_i;
   integer   k;
   always @* begin
      tp_v = 1'b0;
      tp_i = 4'h0;
      for (k = 0; k < NT; k = k + 1) begin
         if (tpend_r[k]) begin
            tp_v = 1'b1;
            tp_i = k[3:0];
         end
      end
   end

   wire       trap_go = tp_v & (~tact_r | (tp_i > tlvl_r));
   wire       idle_ok = (state_r == ST_IDLE) & ~tact_r;
   wire       take_sw = idle_ok & sw_pend_r & ~int_act_r;
   wire       take_nd = idle_ok & ~take_sw & best_v;
   wire [2:0] bch     = node_chan_i[best_i*3 +: 3];
   wire [`SRQ_CB_W-1:0] bcfg = cfg_of(bch);
   wire       bcont   = bcfg[`SRQ_CB_CONT];
   wire       last_x  = take_nd & best_x & ~bcont &
                        (cnt_r[bch] == {{(`SRQ_CNT_W-1){1'b0}}, 1'b1});
   wire [`SRQ_PTR_W-1:0] step =
      bcfg[`SRQ_CB_WORD] ? {{(`SRQ_PTR_W-2){1'b0}}, 2'h2}
                         : {{(`SRQ_PTR_W-1){1'b0}}, 1'b1};
   wire       vtake   = (state_r == ST_WAIT) & (lat_r == 4'h0);

   // Request flags: sources, software sets and count-zero reposts set,
   // the start of a service clears; a set in the same cycle wins.
   reg [NODES-1:0] req_nxt;
   always @* begin
      req_nxt = req_r;
      if (take_nd)
         req_nxt[best_i] = 1'b0;
      req_nxt = req_nxt | src_eff | node_set_i;
      if (last_x)
         req_nxt[best_i] = 1'b1;
   end

   // Service sequencer and flag state.
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r   <= ST_IDLE;
         lat_r     <= 4'h0;
         req_r     <= {NODES{1'b0}};
         force_r   <= {NODES{1'b0}};
         int_act_r <= 1'b0;
         sw_pend_r <= 1'b0;
         vec_r     <= 7'h00;
         gate_r    <= {`SRQ_ERU_CH{1'b0}};
      end else begin
         req_r  <= req_nxt;
         gate_r <= gate_nxt;
         // A trap instruction is held until the sequencer can take it.
         sw_pend_r <= (sw_pend_r & ~take_sw) | sw_trap_i;
         if (last_x)
            force_r[best_i] <= 1'b1;
         else if (take_nd & ~best_x)
            force_r[best_i] <= 1'b0;
         if (vtake)
            int_act_r <= 1'b1;
         else if (int_done_i)
            int_act_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (take_sw | (take_nd & ~best_x)) begin
                  state_r <= ST_WAIT;
                  lat_r   <= (jump_cache_i ? `SRQ_LAT_JC
                                           : `SRQ_LAT_NJC) - 4'h1;
                  vec_r   <= take_sw ? sw_trap_num_i
                                     : {1'b0, best_i};
               end else if (take_nd) begin
                  state_r <= ST_XFER;
               end
            end
            ST_WAIT: begin
               if (lat_r == 4'h0)
                  state_r <= ST_IDLE;
               else
                  lat_r <= lat_r - 4'h1;
            end
            ST_XFER: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Transfer channels: software load wins over an update in that cycle.
   integer c;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (c = 0; c < CHANS; c = c + 1) begin
            src_ptr_r[c] <= {`SRQ_PTR_W{1'b0}};
            dst_ptr_r[c] <= {`SRQ_PTR_W{1'b0}};
            cnt_r[c]     <= {`SRQ_CNT_W{1'b0}};
         end
         xsrc_r  <= {`SRQ_PTR_W{1'b0}};
         xdst_r  <= {`SRQ_PTR_W{1'b0}};
         xword_r <= 1'b0;
         xchan_r <= 3'h0;
      end else begin
         if (take_nd & best_x) begin
            xsrc_r  <= src_ptr_r[bch];
            xdst_r  <= dst_ptr_r[bch];
            xword_r <= bcfg[`SRQ_CB_WORD];
            xchan_r <= bch;
         end
         for (c = 0; c < CHANS; c = c + 1) begin
            if (chan_wr_i & (chan_idx_i == c[2:0])) begin
               src_ptr_r[c] <= chan_src_i;
               dst_ptr_r[c] <= chan_dst_i;
               cnt_r[c]     <= chan_cnt_i;
            end else if (take_nd & best_x & (bch == c[2:0])) begin
               if (bcfg[`SRQ_CB_INCS])
                  src_ptr_r[c] <= src_ptr_r[c] + step;
               if (bcfg[`SRQ_CB_INCD])
                  dst_ptr_r[c] <= dst_ptr_r[c] + step;
               if (~bcont)
                  cnt_r[c] <= cnt_r[c] - {{(`SRQ_CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // Traps: the indicator keeps a set over a clear in the same cycle.
   // Only one trap level is remembered; a preempted trap is not resumed.
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tflag_r <= {NT{1'b0}};
         tpend_r <= {NT{1'b0}};
         tact_r  <= 1'b0;
         tlvl_r  <= 4'h0;
         ttake_r <= 1'b0;
         tvec_r  <= 4'h0;
      end else begin
         tflag_r <= (tflag_r & ~trap_clr_i) | trap_ev;
         ttake_r <= trap_go;
         if (trap_go) begin
            tpend_r       <= tpend_r | trap_ev;
            tpend_r[tp_i] <= trap_ev[tp_i];
            tact_r        <= 1'b1;
            tlvl_r        <= tp_i;
            tvec_r        <= tp_i;
         end else begin
            tpend_r <= tpend_r | trap_ev;
            if (trap_done_i)
               tact_r <= 1'b0;
         end
      end
   end

   assign pending_request_bit_o     = req_r;
   assign int_active_o              = int_act_r;
   assign vec_take_o                = vtake;
   assign vec_num_o                 = vec_r;
   assign steal_o                   = (state_r == ST_XFER);
   assign xfer_src_o                = xsrc_r;
   assign xfer_dst_o                = xdst_r;
   assign xfer_word_o               = xword_r;
   assign xfer_chan_o               = xchan_r;
   assign trap_indicator_register_o = tflag_r;
   assign trap_active_o             = tact_r;
   assign trap_take_o               = ttake_r;
   assign trap_vec_o                = tvec_r;
   assign eru_evt_o                 = gate_r;
endmodule
`default_nettype wire

/* File: core/srq_defs.vh */
// Purpose: Shared constants of the service request controller.
// Assumes: Included by bare name from every design file.
// Notes:   Definitions only.
`ifndef SRQ_DEFS_VH
`define SRQ_DEFS_VH
`define SRQ_NODES     46
`define SRQ_CHANS     8
`define SRQ_HWTRAPS   8
`define SRQ_ERU_CH    4
`define SRQ_ESR_PINS  3
`define SRQ_SHARED    4
`define SRQ_PRIO_W    4
`define SRQ_PTR_W     24
`define SRQ_CNT_W     8
// Interrupt response latency in CPU clocks, with and without jump cache.
`define SRQ_LAT_JC    4'd7
`define SRQ_LAT_NJC   4'd11
// Per-channel configuration bit positions.
`define SRQ_CB_WORD   0
`define SRQ_CB_INCS   1
`define SRQ_CB_INCD   2
`define SRQ_CB_CONT   3
`define SRQ_CB_W      4
// Edge detection modes.
`define SRQ_EDGE_RISE 2'h1
`define SRQ_EDGE_FALL 2'h2
`define SRQ_EDGE_BOTH 2'h3
// Output gate modes.
`define SRQ_GATE_OFF  2'h0
`define SRQ_GATE_ALL  2'h1
`define SRQ_GATE_HIT  2'h2
`define SRQ_GATE_MISS 2'h3
`endif

/* File: core/srq_edge_stage.v */
// Purpose: Synchronise one pin and detect a selectable edge on it.
// Assumes: The pin is asynchronous to mclk_i.
// Notes:   Event pulse comes from a flop, three cycles after the pin moves.
`timescale 1ns/1ns
`default_nettype none
`include "srq_defs.vh"
module srq_edge_stage (
   input  wire       mclk_i,
   input  wire       rst_n_i,
   input  wire       pin_i,
   input  wire [1:0] mode_i,
   output wire       level_o,
   output wire       evt_o
);
   reg sync1_r;
   reg sync2_r;
   reg prev_r;
   reg evt_r;
   // Edges are ignored until prev_r holds a synchronised level, so a pin
   // that idles high gives no false rise just after reset.
   reg [2:0] arm_r;
   wire rise = sync2_r & ~prev_r;
   wire fall = ~sync2_r & prev_r;

   // Two flops before any logic looks at the pin; prev_r holds history.
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
         evt_r   <= 1'b0;
         arm_r   <= 3'h0;
      end else begin
         arm_r   <= {arm_r[1:0], 1'b1};
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
         evt_r   <= arm_r[2] &
                    ((mode_i[0] & rise) | (mode_i[1] & fall));
      end
   end

   assign level_o = sync2_r;
   assign evt_o   = evt_r;
endmodule
`default_nettype wire

/* File: dv/srq_cpu_model.sv */
// Purpose: CPU side partner that returns from vector and trap branches.
// Assumes: Branch pulses are one cycle wide on mclk_i.
// Notes:   slow_i stretches the routine so that waiting logic shows.
`timescale 1ns/1ns
`default_nettype none
module srq_cpu_model (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic slow_i,
   input  wire logic vec_take_i,
   input  wire logic trap_take_i,
   output var  logic int_done_o,
   output var  logic trap_done_o
);
   logic [3:0] int_cnt_r;
   logic [3:0] trap_cnt_r;
   // A new branch restarts its routine, so a preempted trap returns once.
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_cnt_r   <= 4'h0;
         trap_cnt_r  <= 4'h0;
         int_done_o  <= 1'b0;
         trap_done_o <= 1'b0;
      end else begin
         int_done_o  <= (int_cnt_r == 4'h1);
         trap_done_o <= (trap_cnt_r == 4'h1);
         if (vec_take_i)
            int_cnt_r <= slow_i ? 4'h9 : 4'h2;
         else if (int_cnt_r != 4'h0)
            int_cnt_r <= int_cnt_r - 4'h1;
         if (trap_take_i)
            trap_cnt_r <= slow_i ? 4'h9 : 4'h2;
         else if (trap_cnt_r != 4'h0)
            trap_cnt_r <= trap_cnt_r - 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: dv/srq_ctrl_properties.sv */
// Purpose: Timing relations of the service request controller ports.
// Assumes: One clock domain, reset active low.
// Notes:   Trap latency holds only when no other trap is in flight.
`timescale 1ns/1ns
`default_nettype none
`include "srq_defs.vh"
module srq_ctrl_properties #(
   parameter NODES   = `SRQ_NODES,
   parameter HWTRAPS = `SRQ_HWTRAPS
) (
   input  wire logic                  mclk_i,
   input  wire logic                  rst_n_i,
   input  wire logic [NODES-1:0]      node_set_i,
   input  wire logic [HWTRAPS-1:0]    hw_trap_i,
   input  wire logic [NODES-1:0]      pending_request_bit_o,
   input  wire logic                  int_active_o,
   input  wire logic                  vec_take_o,
   input  wire logic                  steal_o,
   input  wire logic [`SRQ_PTR_W-1:0] xfer_src_o,
   input  wire logic [HWTRAPS+1:0]    trap_indicator_register_o,
   input  wire logic                  trap_active_o,
   input  wire logic                  trap_take_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Each relation ties an output to the input or state that caused it.
   AST_STEAL_ONE: assert property (steal_o |=> !steal_o)
      else $error("Transfer cycle longer than one clock.");
   AST_VEC_ACT: assert property (vec_take_o |=> int_active_o)
      else $error("Vector branch without active interrupt.");
   AST_TRAP_ACT: assert property (trap_take_o |-> trap_active_o)
      else $error("Trap branch without active trap.");
   AST_TRAP_BLOCK: assert property ($past(trap_active_o) |-> !steal_o)
      else $error("Transfer started during trap service.");
   AST_IND_SET: assert property (|hw_trap_i |=>
      (trap_indicator_register_o[HWTRAPS-1:0] & $past(hw_trap_i))
      == $past(hw_trap_i)) else $error("Trap indicator not set.");
   AST_TRAP_LAT: assert property ((|hw_trap_i && !trap_active_o)
      |-> ##2 trap_take_o) else $error("Trap not taken in two clocks.");
   AST_SET_FLAG: assert property (|node_set_i |=>
      |(pending_request_bit_o & $past(node_set_i)))
      else $error("Software set did not raise a request flag.");
   AST_XFER_HOLD: assert property ($changed(xfer_src_o) |-> steal_o)
      else $error("Transfer pointer moved outside a transfer.");
   COV_STEAL: cover property (steal_o);
   COV_VEC: cover property (vec_take_o);
   COV_PREEMPT: cover property (trap_take_o && $past(trap_active_o));
endmodule
bind srq_ctrl srq_ctrl_properties #(.NODES(NODES), .HWTRAPS(HWTRAPS)) chk_u (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .node_set_i(node_set_i),
   .hw_trap_i(hw_trap_i), .pending_request_bit_o(pending_request_bit_o),
   .int_active_o(int_active_o), .vec_take_o(vec_take_o),
   .steal_o(steal_o), .xfer_src_o(xfer_src_o),
   .trap_indicator_register_o(trap_indicator_register_o),
   .trap_active_o(trap_active_o), .trap_take_o(trap_take_o));
`default_nettype wire

/* File: dv/srq_ctrl_test.sv */
// Purpose: Self-checking bench of the service request controller.
// Assumes: Inputs change at the falling edge of mclk_i.
// Notes:   Latency counts from the edge that takes the request flag.
`timescale 1ns/1ns
`default_nettype none
`include "srq_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module srq_ctrl_test;
   typedef struct packed {logic [5:0] node; logic jc; logic slow;
      logic hw; logic [3:0] lat;} srq_row_t;
   srq_row_t rows [3] = '{'{6'd0, 1'b1, 1'b0, 1'b0, `SRQ_LAT_JC},
      '{6'd45, 1'b0, 1'b1, 1'b1, `SRQ_LAT_NJC},
      '{6'd20, 1'b1, 1'b1, 1'b0, `SRQ_LAT_JC}};
   int n_errors = 0;
   int checks = 0;
   int lat_n;
   logic mclk_i, rst_n_i, sw_trap, jc, chan_wr, slow;
   logic [45:0] src_req, node_set, node_en, node_xfer;
   logic [183:0] node_prio;
   logic [137:0] node_chan;
   logic [3:0] nsel, eru_pin;
   logic [7:0] eru_edge, eru_gmode, hw_trap, chan_cnt;
   logic [15:0] eru_route, eru_pat;
   logic [2:0] esr_pin, esr_en, chan_idx;
   logic [9:0] trap_clr;
   logic [6:0] sw_num;
   logic [23:0] chan_src, chan_dst;
   logic [31:0] chan_cfg;
   wire logic [45:0] pend;
   wire logic int_act, vec_take, steal, xword, trap_act, trap_take;
   wire logic int_done, trap_done;
   wire logic [6:0] vec_num;
   wire logic [23:0] xsrc, xdst;
   wire logic [2:0] xchan;
   wire logic [9:0] tind;
   wire logic [3:0] tvec, evt;
   srq_ctrl dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .src_req_i(src_req),
      .node_set_i(node_set), .node_en_i(node_en), .node_prio_i(node_prio),
      .node_xfer_i(node_xfer), .node_chan_i(node_chan),
      .node_source_select_i(nsel), .eru_pin_i(eru_pin),
      .eru_edge_i(eru_edge), .eru_route_i(eru_route), .eru_pat_i(eru_pat),
      .eru_gmode_i(eru_gmode), .service_request_pin_i(esr_pin),
      .esr_en_i(esr_en), .hw_trap_i(hw_trap), .trap_clr_i(trap_clr),
      .trap_done_i(trap_done), .sw_trap_i(sw_trap), .sw_trap_num_i(sw_num),
      .jump_cache_i(jc), .int_done_i(int_done), .chan_wr_i(chan_wr),
      .chan_idx_i(chan_idx), .chan_src_i(chan_src), .chan_dst_i(chan_dst),
      .chan_cnt_i(chan_cnt), .chan_cfg_i(chan_cfg),
      .pending_request_bit_o(pend), .int_active_o(int_act),
      .vec_take_o(vec_take), .vec_num_o(vec_num), .steal_o(steal),
      .xfer_src_o(xsrc), .xfer_dst_o(xdst), .xfer_word_o(xword),
      .xfer_chan_o(xchan), .trap_indicator_register_o(tind),
      .trap_active_o(trap_act), .trap_take_o(trap_take),
      .trap_vec_o(tvec), .eru_evt_o(evt));
   srq_cpu_model cpu_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow),
      .vec_take_i(vec_take), .trap_take_i(trap_take),
      .int_done_o(int_done), .trap_done_o(trap_done));
   // Free-running clock at 100 MHz.
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk_i);
   endtask
   // Pulses end after one cycle; the wait is bounded so a hang is a miss.
   task automatic wait_for(input int sel);
      bit hit;
      hit = 1'b0;
      lat_n = 0;
      while (!hit && lat_n < 40) begin
         @(negedge mclk_i);
         lat_n++;
         {node_set, src_req, hw_trap, sw_trap, chan_wr} = '0;
         hit = sel == 0 ? vec_take === 1'b1 : sel == 1 ? steal === 1'b1 :
               sel == 2 ? trap_take === 1'b1 : evt !== 4'h0;
      end
      `CHK("handshake", 1'b1, hit)
   endtask
   task automatic load(input logic [2:0] i, input logic [23:0] s, d,
                       input logic [7:0] n);
      {chan_wr, chan_idx, chan_src, chan_dst, chan_cnt} = {1'b1, i, s, d, n};
      cyc(1);
      chan_wr = 1'b0;
      cyc(1);
   endtask
   task automatic xfer(input int nd, input logic [23:0] s, d,
                       input logic w, input logic [2:0] c);
      node_set[nd] = 1'b1;
      wait_for(1);
      `CHK("xfer_src", s, xsrc)
      `CHK("xfer_dst", d, xdst)
      `CHK("xfer_word", w, xword)
      `CHK("xfer_chan", c, xchan)
      cyc(2);
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Cuts a hang short well beyond the length of the sequence.
   initial begin
      #100000;
      n_errors++;
      wrap_up();
   end
   // Main sequence: reset, table of vectored services, then special cases.
   initial begin
      {src_req, node_set, node_xfer, node_chan, hw_trap, trap_clr} = '0;
      {sw_trap, sw_num, jc, chan_wr, chan_idx, slow, esr_pin} = '0;
      {chan_src, chan_dst, chan_cnt, chan_cfg} = '0;
      node_en = ~46'h0;
      node_en[9] = 1'b0;
      node_en[42] = 1'b0;
      node_prio = {46{4'h1}};
      node_xfer[6:5] = 2'h3;
      node_chan[15+:3] = 3'h2;
      node_chan[18+:3] = 3'h3;
      chan_cfg[8+:4] = 4'h7;
      chan_cfg[12+:4] = 4'ha;
      {nsel, eru_pin, esr_en, eru_edge} = {4'h1, 4'h2, 3'h7, 8'h09};
      {eru_route, eru_pat, eru_gmode} = {16'h1121, 16'h03f0, 8'hb7};
      rst_n_i = 1'b0;
      cyc(12);
      rst_n_i = 1'b1;
      `CHK("pending", 46'h0, pend)
      `CHK("trap_ind", 10'h0, tind)
      `CHK("int_active", 1'b0, int_act)
      foreach (rows[i]) begin
         {jc, slow} = {rows[i].jc, rows[i].slow};
         if (rows[i].hw)
            src_req[rows[i].node] = 1'b1;
         else
            node_set[rows[i].node] = 1'b1;
         wait_for(0);
         `CHK("latency", rows[i].lat + 5'd1, lat_n)
         `CHK("vector", {1'b0, rows[i].node}, vec_num)
         cyc(14);
      end
      node_prio[12+:4] = 4'h2;
      node_prio[28+:4] = 4'h9;
      {node_set[3], node_set[7]} = 2'h3;
      wait_for(0);
      `CHK("vector", 7'd7, vec_num)
      `CHK("pending3", 1'b1, pend[3])
      wait_for(0);
      `CHK("vector", 7'd3, vec_num)
      node_set[9] = 1'b1;
      cyc(1);
      node_set = '0;
      cyc(14);
      `CHK("pending9", 1'b1, pend[9])
      load(3'h2, 24'h000100, 24'h000200, 8'h02);
      load(3'h3, 24'h000300, 24'h000400, 8'h01);
      xfer(5, 24'h000100, 24'h000200, 1'b1, 3'h2);
      xfer(5, 24'h000102, 24'h000202, 1'b1, 3'h2);
      // The exhausted count re-posts the node itself as a vector.
      wait_for(0);
      `CHK("vector", 7'd5, vec_num)
      cyc(14);
      // Continuous channel with count one steals twice with no vector.
      xfer(6, 24'h000300, 24'h000400, 1'b0, 3'h3);
      xfer(6, 24'h000301, 24'h000400, 1'b0, 3'h3);
      slow = 1'b1;
      hw_trap[3] = 1'b1;
      wait_for(2);
      `CHK("trap_vec", 4'h3, tvec)
      `CHK("trap_ind3", 1'b1, tind[3])
      node_set[10] = 1'b1;
      cyc(1);
      node_set = '0;
      cyc(3);
      `CHK("pending10", 1'b1, pend[10])
      hw_trap[6] = 1'b1;
      wait_for(2);
      `CHK("trap_vec", 4'h6, tvec)
      hw_trap[2] = 1'b1;
      cyc(1);
      hw_trap = '0;
      cyc(4);
      `CHK("trap_vec", 4'h6, tvec)
      wait_for(0);
      `CHK("vector", 7'd10, vec_num)
      trap_clr = 10'h3ff;
      cyc(1);
      trap_clr = '0;
      cyc(1);
      `CHK("trap_ind", 10'h0, tind)
      slow = 1'b0;
      esr_pin[0] = 1'b1;
      cyc(8);
      `CHK("sysreq0", 1'b1, tind[8])
      esr_pin[2] = 1'b1;
      cyc(8);
      `CHK("sysreq1", 1'b1, tind[9])
      cyc(10);
      {sw_num, sw_trap} = {7'h55, 1'b1};
      wait_for(0);
      `CHK("vector", 7'h55, vec_num)
      cyc(10);
      eru_pin[0] = 1'b1;
      wait_for(3);
      `CHK("gate_evt", 4'h1, evt)
      cyc(3);
      `CHK("pending42", 1'b1, pend[42])
      eru_pin[1] = 1'b0;
      wait_for(3);
      `CHK("gate_evt", 4'h2, evt)
      wrap_up();
   end
endmodule
`default_nettype wire
